// ==== src/sccs_pkg.sv ====
// constants, types and decode helpers for the sensor command and status registers
// What this block does
// RL1: host writes command code plus argument bytes
// RL2: code 0x47 loads serial number into map
// RL3: host configures aux pins before address change
// RL4: address applied only when masked pins match; code also needs unmasked expected levels zero
// RL5: host keeps condition high nibble zero
// RL6: new address taken from argument bits 7:1
// RL7: code 0x80 starts histogram block transfer
// RL8: window, contents and id update together
// RL9: code 0xFF aborts activity, returns idle
// RL10: stop also ends continuous measurement
// RL11: last command shows running measure/calibration
// RL12: operation state reads 2 on failure
// RL13: status 00h-0Fh ok, 10h-FFh error
// RL14: transaction id changes on map update
package sccs_pkg;
    // register byte offsets
    localparam logic [7:0] SCCS_OFF_NEW_ADDR = 8'h0E;
    localparam logic [7:0] SCCS_OFF_COND = 8'h0F;
    localparam logic [7:0] SCCS_OFF_CMD = 8'h10;
    localparam logic [7:0] SCCS_OFF_LAST = 8'h11;
    localparam logic [7:0] SCCS_OFF_REV_MINOR = 8'h12;
    localparam logic [7:0] SCCS_OFF_REV_PATCH = 8'h13;
    localparam logic [7:0] SCCS_OFF_STATE = 8'h1C;
    localparam logic [7:0] SCCS_OFF_STATUS = 8'h1D;
    localparam logic [7:0] SCCS_OFF_CONTENTS = 8'h1E;
    localparam logic [7:0] SCCS_OFF_TID = 8'h1F;
    localparam logic [7:0] SCCS_OFF_WIN_LO = 8'h20;
    localparam logic [7:0] SCCS_OFF_WIN_HI = 8'h9F;
    // command codes
    localparam logic [7:0] SCCS_CMD_MEASURE = 8'h02;
    localparam logic [7:0] SCCS_CMD_CALIB = 8'h0A;
    localparam logic [7:0] SCCS_CMD_PIN_CFG = 8'h0F;
    localparam logic [7:0] SCCS_CMD_SERIAL = 8'h47;
    localparam logic [7:0] SCCS_CMD_ADDR = 8'h49;
    localparam logic [7:0] SCCS_CMD_HIST = 8'h80;
    localparam logic [7:0] SCCS_CMD_STOP = 8'hFF;
    // condition byte fields
    localparam int SCCS_COND_MASK0_BIT = 0;
    localparam int SCCS_COND_MASK1_BIT = 1;
    localparam int SCCS_COND_VAL0_BIT = 2;
    localparam int SCCS_COND_VAL1_BIT = 3;
    localparam int SCCS_ADDR_LSB = 1;
    // reset values
    localparam logic [7:0] SCCS_RST_BYTE = 8'h00;
    localparam logic [6:0] SCCS_RST_CNT = 7'h00;
    // operation state and status codes
    localparam logic [7:0] SCCS_OPST_IDLE = 8'h00;
    localparam logic [7:0] SCCS_OPST_BUSY = 8'h01;
    localparam logic [7:0] SCCS_OPST_ERROR = 8'h02;
    localparam logic [7:0] SCCS_STAT_OK = 8'h00;
    localparam logic [7:0] SCCS_STAT_ERR_MIN = 8'h10;
    localparam logic [7:0] SCCS_STAT_BAD_CMD = 8'h10;
    localparam logic [7:0] SCCS_STAT_COND_FAIL = 8'h11;
    // map contents and sizes
    localparam logic [7:0] SCCS_CONTENTS_SERIAL = 8'h47;
    localparam int SCCS_WIN_DEPTH = 128;
    localparam logic [6:0] SCCS_WIN_LAST = 7'h7F;
    localparam logic [6:0] SCCS_SERIAL_LAST = 7'h03;

    typedef enum logic [3:0] {
        SCCS_ST_IDLE = 4'h1,
        SCCS_ST_SERIAL = 4'h2,
        SCCS_ST_HIST = 4'h4,
        SCCS_ST_RUN = 4'h8
    } sccs_state_t;

    // true for every code this block executes
    function automatic logic sccs_known_cmd(input logic [7:0] code);
        return (code == SCCS_CMD_MEASURE) || (code == SCCS_CMD_CALIB) ||
            (code == SCCS_CMD_PIN_CFG) || (code == SCCS_CMD_SERIAL) ||
            (code == SCCS_CMD_ADDR) || (code == SCCS_CMD_HIST) || (code == SCCS_CMD_STOP);
    endfunction
endpackage

// ==== src/sccs_addr_cond.sv ====
// aux pin synchroniser and address-change condition check
`timescale 1ns/10ps
module sccs_addr_cond
    import sccs_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic aux_pin_zero_in,
    input wire logic aux_pin_one_in,
    input wire logic [7:0] condition_argument_in,
    output logic cond_met_out
);
    logic [1:0] meta_q, meta_d;
    logic [1:0] pins_q, pins_d;
    logic pin0_compare_mask, pin1_compare_mask;
    logic pin0_expected_level, pin1_expected_level;

    // pins come from outside, two flops before use
    always_comb begin
        meta_d = {aux_pin_one_in, aux_pin_zero_in};
        pins_d = meta_q;
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            meta_q <= 2'h0;
            pins_q <= 2'h0;
        end else begin
            meta_q <= meta_d;
            pins_q <= pins_d;
        end
    end

    // bits above the four fields are ignored, the host keeps them zero
    always_comb begin
        pin0_compare_mask = condition_argument_in[SCCS_COND_MASK0_BIT];
        pin1_compare_mask = condition_argument_in[SCCS_COND_MASK1_BIT];
        pin0_expected_level = condition_argument_in[SCCS_COND_VAL0_BIT];
        pin1_expected_level = condition_argument_in[SCCS_COND_VAL1_BIT];
        cond_met_out = ({pin1_compare_mask & pins_q[1], pin0_compare_mask & pins_q[0]} ==
            {pin1_expected_level, pin0_expected_level}); // RL4
    end

    property p_uncond;
        @(posedge clk_sys_in) disable iff (srst_in)
        (condition_argument_in == SCCS_RST_BYTE) |-> cond_met_out;
    endproperty
    a_uncond: assert property (p_uncond) else $error("zero condition did not match"); // RL5
endmodule

// ==== src/sccs_top.sv ====
// command interpreter and status registers of the sensor register map
`timescale 1ns/10ps
module sccs_top
    import sccs_pkg::*;
#(
    parameter logic [6:0] RESET_BUS_ADDR = 7'h29, // arbitrary default
    parameter logic [7:0] REV_MINOR = 8'h01, // arbitrary value
    parameter logic [7:0] REV_PATCH = 8'h02 // arbitrary value
)
(
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic [6:0] bus_addr_out,
    input wire logic aux_pin_zero_in,
    input wire logic aux_pin_one_in,
    input wire logic [31:0] serial_number_in,
    input wire logic hist_valid_in,
    input wire logic [7:0] hist_data_in,
    input wire logic [7:0] hist_kind_in,
    output logic hist_ready_out,
    output logic meas_start_out,
    output logic meas_continuous_out,
    input wire logic meas_busy_in,
    output logic abort_out
);
    sccs_state_t st_q, st_d;
    logic [6:0] cnt_q, cnt_d;
    logic [7:0] last_q, last_d;
    logic [7:0] opst_q, opst_d;
    logic [7:0] status_q, status_d;
    logic [7:0] contents_q, contents_d;
    logic [7:0] tid_q, tid_d;
    logic [6:0] addr_q, addr_d;
    logic [7:0] cond_q, cond_d;
    logic [7:0] new_addr_q, new_addr_d;
    logic cont_q, cont_d;
    logic start_q, start_d;
    logic abort_q, abort_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] win_mem [SCCS_WIN_DEPTH];
    logic win_we;
    logic [6:0] win_widx, win_ridx;
    logic [7:0] win_wdata;
    logic cmd_wr, stop_wr, cond_met;
    logic [6:0] addr_field;

    sccs_addr_cond u_cond (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .aux_pin_zero_in(aux_pin_zero_in),
        .aux_pin_one_in(aux_pin_one_in),
        .condition_argument_in(cond_q),
        .cond_met_out(cond_met)
    );

    // command register strobes
    assign cmd_wr = reg_wr_in && (reg_addr_in == SCCS_OFF_CMD); // RL1
    assign stop_wr = cmd_wr && (reg_wdata_in == SCCS_CMD_STOP);
    assign addr_field = new_addr_q[7:SCCS_ADDR_LSB];

    // argument bytes are plain storage, written any time
    always_comb begin
        cond_d = cond_q;
        new_addr_d = new_addr_q;
        if (reg_wr_in && (reg_addr_in == SCCS_OFF_COND)) begin
            cond_d = reg_wdata_in;
        end
        if (reg_wr_in && (reg_addr_in == SCCS_OFF_NEW_ADDR)) begin
            new_addr_d = reg_wdata_in;
        end
    end

    // command sequencer; while busy only stop is honoured, others are dropped
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        last_d = last_q;
        opst_d = opst_q;
        status_d = status_q;
        contents_d = contents_q;
        tid_d = tid_q;
        addr_d = addr_q;
        cont_d = cont_q;
        start_d = 1'b0;
        abort_d = 1'b0;
        win_we = 1'b0;
        win_widx = cnt_q;
        win_wdata = hist_data_in;
        hist_ready_out = 1'b0;
        if (stop_wr) begin
            st_d = SCCS_ST_IDLE; // RL9
            cont_d = 1'b0; // RL10
            abort_d = 1'b1;
            last_d = SCCS_CMD_STOP;
            opst_d = SCCS_OPST_IDLE;
            status_d = SCCS_STAT_OK;
        end else begin
            unique case (st_q)
                SCCS_ST_IDLE: begin
                    if (cmd_wr) begin
                        cnt_d = SCCS_RST_CNT;
                        opst_d = SCCS_OPST_BUSY;
                        status_d = SCCS_STAT_OK;
                        if (!sccs_known_cmd(reg_wdata_in)) begin
                            opst_d = SCCS_OPST_ERROR; // RL12
                            status_d = SCCS_STAT_BAD_CMD; // RL13
                        end else if (reg_wdata_in == SCCS_CMD_SERIAL) begin
                            st_d = SCCS_ST_SERIAL; // RL2
                        end else if (reg_wdata_in == SCCS_CMD_HIST) begin
                            st_d = SCCS_ST_HIST; // RL7
                        end else if (reg_wdata_in == SCCS_CMD_ADDR) begin
                            last_d = reg_wdata_in;
                            if (cond_met) begin
                                addr_d = addr_field; // RL6
                                opst_d = SCCS_OPST_IDLE;
                            end else begin
                                opst_d = SCCS_OPST_ERROR; // RL4
                                status_d = SCCS_STAT_COND_FAIL;
                            end
                        end else if ((reg_wdata_in == SCCS_CMD_MEASURE) ||
                            (reg_wdata_in == SCCS_CMD_CALIB)) begin
                            // the running code is shown as soon as it starts
                            last_d = reg_wdata_in; // RL11
                            start_d = 1'b1;
                            cont_d = (reg_wdata_in == SCCS_CMD_MEASURE);
                            st_d = SCCS_ST_RUN;
                        end else begin
                            last_d = reg_wdata_in;
                            opst_d = SCCS_OPST_IDLE;
                        end
                    end
                end
                SCCS_ST_SERIAL: begin
                    win_we = 1'b1;
                    win_wdata = serial_number_in[{cnt_q[1:0], 3'h0} +: 8];
                    cnt_d = 7'(cnt_q + 7'h01);
                    if (cnt_q == SCCS_SERIAL_LAST) begin
                        contents_d = SCCS_CONTENTS_SERIAL; // RL2
                        tid_d = 8'(tid_q + 8'h01); // RL14
                        last_d = SCCS_CMD_SERIAL;
                        opst_d = SCCS_OPST_IDLE;
                        st_d = SCCS_ST_IDLE;
                    end
                end
                SCCS_ST_HIST: begin
                    hist_ready_out = 1'b1;
                    if (hist_valid_in) begin
                        win_we = 1'b1;
                        cnt_d = 7'(cnt_q + 7'h01);
                        if (cnt_q == SCCS_WIN_LAST) begin
                            // contents and id move in the cycle the last byte lands
                            contents_d = hist_kind_in; // RL8
                            tid_d = 8'(tid_q + 8'h01); // RL14
                            last_d = SCCS_CMD_HIST;
                            opst_d = SCCS_OPST_IDLE;
                            st_d = SCCS_ST_IDLE;
                        end
                    end
                end
                SCCS_ST_RUN: begin
                    // continuous measuring only leaves through stop
                    if (!cont_q && !start_q && !meas_busy_in) begin
                        opst_d = SCCS_OPST_IDLE;
                        st_d = SCCS_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // read mux; window index only meaningful inside the window range
    always_comb begin
        win_ridx = 7'(reg_addr_in - SCCS_OFF_WIN_LO);
        rdata_d = rdata_q;
        if (reg_rd_in) begin
            rdata_d = SCCS_RST_BYTE;
            if ((reg_addr_in >= SCCS_OFF_WIN_LO) && (reg_addr_in <= SCCS_OFF_WIN_HI)) begin
                rdata_d = win_mem[win_ridx];
            end else begin
                unique case (reg_addr_in)
                    SCCS_OFF_NEW_ADDR: rdata_d = new_addr_q;
                    SCCS_OFF_COND: rdata_d = cond_q;
                    SCCS_OFF_LAST: rdata_d = last_q; // RL11
                    SCCS_OFF_REV_MINOR: rdata_d = REV_MINOR;
                    SCCS_OFF_REV_PATCH: rdata_d = REV_PATCH;
                    SCCS_OFF_STATE: rdata_d = opst_q; // RL12
                    SCCS_OFF_STATUS: rdata_d = status_q; // RL13
                    SCCS_OFF_CONTENTS: rdata_d = contents_q;
                    SCCS_OFF_TID: rdata_d = tid_q;
                    default: rdata_d = SCCS_RST_BYTE;
                endcase
            end
        end
    end

    // window storage has no reset, it is data only
    always_ff @(posedge clk_sys_in) begin
        if (win_we) begin
            win_mem[win_widx] <= win_wdata;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            st_q <= SCCS_ST_IDLE;
            cnt_q <= SCCS_RST_CNT;
            last_q <= SCCS_RST_BYTE;
            opst_q <= SCCS_RST_BYTE;
            status_q <= SCCS_RST_BYTE;
            contents_q <= SCCS_RST_BYTE;
            tid_q <= SCCS_RST_BYTE;
            addr_q <= RESET_BUS_ADDR;
            cond_q <= SCCS_RST_BYTE;
            new_addr_q <= SCCS_RST_BYTE;
            cont_q <= 1'b0;
            start_q <= 1'b0;
            abort_q <= 1'b0;
            rdata_q <= SCCS_RST_BYTE;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            last_q <= last_d;
            opst_q <= opst_d;
            status_q <= status_d;
            contents_q <= contents_d;
            tid_q <= tid_d;
            addr_q <= addr_d;
            cond_q <= cond_d;
            new_addr_q <= new_addr_d;
            cont_q <= cont_d;
            start_q <= start_d;
            abort_q <= abort_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign bus_addr_out = addr_q;
    assign meas_start_out = start_q;
    assign meas_continuous_out = cont_q;
    assign abort_out = abort_q;

    // checks on the command sequencer
    property p_serial;
        @(posedge clk_sys_in) disable iff (srst_in)
        (st_q == SCCS_ST_IDLE && cmd_wr && reg_wdata_in == SCCS_CMD_SERIAL) ##1 (!stop_wr)[*4]
        |=> (contents_q == SCCS_CONTENTS_SERIAL) && (st_q == SCCS_ST_IDLE);
    endproperty
    a_serial: assert property (p_serial) else $error("serial readout not completed"); // RL2
    property p_addr_apply;
        @(posedge clk_sys_in) disable iff (srst_in)
        (st_q == SCCS_ST_IDLE && cmd_wr && reg_wdata_in == SCCS_CMD_ADDR && cond_met)
        |=> (bus_addr_out == $past(addr_field));
    endproperty
    a_addr_apply: assert property (p_addr_apply) else $error("new address not applied"); // RL6
    property p_addr_hold;
        @(posedge clk_sys_in) disable iff (srst_in)
        (st_q == SCCS_ST_IDLE && cmd_wr && reg_wdata_in == SCCS_CMD_ADDR && !cond_met)
        |=> $stable(bus_addr_out) && (opst_q == SCCS_OPST_ERROR);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address changed on mismatch"); // RL4
    property p_hist_start;
        @(posedge clk_sys_in) disable iff (srst_in)
        (st_q == SCCS_ST_IDLE && cmd_wr && reg_wdata_in == SCCS_CMD_HIST)
        |=> (st_q == SCCS_ST_HIST) && (cnt_q == SCCS_RST_CNT);
    endproperty
    a_hist_start: assert property (p_hist_start) else $error("histogram transfer not started"); // RL7
    property p_hist_end;
        @(posedge clk_sys_in) disable iff (srst_in)
        (st_q == SCCS_ST_HIST && hist_valid_in && cnt_q == SCCS_WIN_LAST && !stop_wr)
        |=> (tid_q == 8'($past(tid_q) + 8'h01)) && (contents_q == $past(hist_kind_in));
    endproperty
    a_hist_end: assert property (p_hist_end) else $error("histogram end not published"); // RL8
    property p_tid_moves;
        @(posedge clk_sys_in) disable iff (srst_in)
        $changed(contents_q) |-> $changed(tid_q);
    endproperty
    a_tid_moves: assert property (p_tid_moves) else $error("map updated without new id"); // RL14
    property p_stop;
        @(posedge clk_sys_in) disable iff (srst_in)
        stop_wr |=> (st_q == SCCS_ST_IDLE) && abort_out ##1 (abort_out == $past(stop_wr));
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not return to idle"); // RL9
    property p_stop_cont;
        @(posedge clk_sys_in) disable iff (srst_in)
        stop_wr |=> !meas_continuous_out && !meas_start_out;
    endproperty
    a_stop_cont: assert property (p_stop_cont) else $error("continuous mode survived stop"); // RL10
    property p_last_run;
        @(posedge clk_sys_in) disable iff (srst_in)
        (st_q == SCCS_ST_RUN) |-> (last_q == SCCS_CMD_MEASURE || last_q == SCCS_CMD_CALIB);
    endproperty
    a_last_run: assert property (p_last_run) else $error("running code not reported"); // RL11
    property p_bad_cmd;
        @(posedge clk_sys_in) disable iff (srst_in)
        (st_q == SCCS_ST_IDLE && cmd_wr && !sccs_known_cmd(reg_wdata_in))
        |=> (opst_q == SCCS_OPST_ERROR) && (status_q >= SCCS_STAT_ERR_MIN);
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("unknown command not flagged"); // RL12
    property p_status_ok;
        @(posedge clk_sys_in) disable iff (srst_in)
        (opst_q != SCCS_OPST_ERROR) |-> (status_q < SCCS_STAT_ERR_MIN);
    endproperty
    a_status_ok: assert property (p_status_ok) else $error("error status without error state"); // RL13

    c_serial: cover property (@(posedge clk_sys_in) disable iff (srst_in)
        st_q == SCCS_ST_SERIAL ##4 st_q == SCCS_ST_IDLE);
    c_hist: cover property (@(posedge clk_sys_in) disable iff (srst_in)
        st_q == SCCS_ST_HIST && hist_valid_in && cnt_q == SCCS_WIN_LAST);
    c_addr: cover property (@(posedge clk_sys_in) disable iff (srst_in)
        cmd_wr && reg_wdata_in == SCCS_CMD_ADDR && cond_met);
    c_stop_run: cover property (@(posedge clk_sys_in) disable iff (srst_in)
        st_q == SCCS_ST_RUN && stop_wr);
endmodule

// ==== testbench/sccs_host_model.sv ====
// host-side register bus model issuing byte writes, reads and commands
`timescale 1ns/10ps
module sccs_host_model
    import sccs_pkg::*;
(
    input wire logic clk_sys_in,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    input wire logic [7:0] reg_rdata_in
);
    // bus idle from time zero
    initial begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
    end

    // strobe held across the taking edge, dropped at the next falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        reg_wr_out = 1'b1;
        reg_addr_out = a;
        reg_wdata_out = d;
        @(negedge clk_sys_in);
        reg_wr_out = 1'b0;
        reg_wdata_out = ~d; // stale data never lingers on the bus
    endtask

    // read data is registered, so it is settled one falling edge later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_in);
        reg_rd_out = 1'b1;
        reg_addr_out = a;
        @(negedge clk_sys_in);
        reg_rd_out = 1'b0;
        d = reg_rdata_in;
    endtask

    task automatic cmd(input logic [7:0] code);
        wr(SCCS_OFF_CMD, code);
    endtask

    // pins are configured first, arguments precede the command byte
    task automatic addr_change(input logic [7:0] cond, input logic [6:0] na);
        cmd(SCCS_CMD_PIN_CFG);
        wr(SCCS_OFF_COND, cond & 8'h0F);
        wr(SCCS_OFF_NEW_ADDR, {na, 1'b0});
        cmd(SCCS_CMD_ADDR);
    endtask
endmodule

// ==== testbench/test_sensor_command_and_status_regs.sv ====
// self-checking bench for the sensor command and status registers
`timescale 1ns/10ps
module test_sensor_command_and_status_regs;
    import sccs_pkg::*;
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic reg_wr, reg_rd, hist_ready, meas_start, meas_cont, abort;
    logic [7:0] reg_addr, reg_wdata, rdata;
    logic [6:0] bus_addr;
    logic pin0 = 1'b0;
    logic pin1 = 1'b0;
    logic meas_busy = 1'b0;
    logic hist_valid = 1'b0;
    logic [7:0] hist_data = 8'h00;
    logic [7:0] hist_kind = 8'h00;
    logic [31:0] serial = 32'h0;
    logic [7:0] tid = 8'h00;
    int bad_count = 0;
    int check_count = 0;

    always #4 clk_sys_in = ~clk_sys_in;

    sccs_host_model u_host (.clk_sys_in(clk_sys_in), .reg_wr_out(reg_wr),
        .reg_rd_out(reg_rd), .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata),
        .reg_rdata_in(rdata));

    // revisions set to the table's reset value of zero
    sccs_top #(.RESET_BUS_ADDR(7'h29), .REV_MINOR(8'h00), .REV_PATCH(8'h00)) u_dut (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(rdata), .bus_addr_out(bus_addr), .aux_pin_zero_in(pin0),
        .aux_pin_one_in(pin1), .serial_number_in(serial), .hist_valid_in(hist_valid),
        .hist_data_in(hist_data), .hist_kind_in(hist_kind), .hist_ready_out(hist_ready),
        .meas_start_out(meas_start), .meas_continuous_out(meas_cont),
        .meas_busy_in(meas_busy), .abort_out(abort));

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(a, d);
        chk($sformatf("reg %h", a), exp, d);
    endtask

    task automatic report_and_stop();
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic t_reset();
        chk("bus_addr", 8'h29, {1'b0, bus_addr});
        chk_reg(SCCS_OFF_LAST, 8'h00);
        chk_reg(SCCS_OFF_REV_MINOR, 8'h00);
        chk_reg(SCCS_OFF_REV_PATCH, 8'h00);
        chk_reg(SCCS_OFF_STATE, 8'h00);
        chk_reg(SCCS_OFF_STATUS, 8'h00);
        chk_reg(SCCS_OFF_TID, 8'h00);
        u_host.wr(SCCS_OFF_LAST, 8'h5A);
        chk_reg(SCCS_OFF_LAST, 8'h00);
        chk_reg(8'hA0, 8'h00);
    endtask

    task automatic t_serial();
        serial = 32'hA1B2C3D4;
        u_host.cmd(SCCS_CMD_SERIAL);
        repeat (6) @(negedge clk_sys_in);
        for (int i = 0; i < 4; i++) begin
            chk_reg(SCCS_OFF_WIN_LO + 8'(i), serial[8*i +: 8]);
        end
        tid = tid + 8'h01;
        chk_reg(SCCS_OFF_CONTENTS, SCCS_CONTENTS_SERIAL);
        chk_reg(SCCS_OFF_TID, tid);
        chk_reg(SCCS_OFF_LAST, SCCS_CMD_SERIAL);
    endtask

    // pin0 high, pin1 low; unmasked expected levels still take part
    task automatic t_addr();
        logic [7:0] conds [6] = '{8'h00, 8'h05, 8'h07, 8'h0D, 8'h02, 8'h01};
        logic met [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
        logic [6:0] exp_addr;
        pin0 = 1'b1;
        exp_addr = 7'h29;
        repeat (4) @(negedge clk_sys_in);
        for (int i = 0; i < 6; i++) begin
            u_host.addr_change(conds[i], 7'h30 + 7'(i));
            if (met[i]) exp_addr = 7'h30 + 7'(i);
            chk("bus_addr", {1'b0, exp_addr}, {1'b0, bus_addr});
            chk_reg(SCCS_OFF_STATE, met[i] ? SCCS_OPST_IDLE : SCCS_OPST_ERROR);
            chk_reg(SCCS_OFF_STATUS, met[i] ? SCCS_STAT_OK : SCCS_STAT_COND_FAIL);
        end
    endtask

    // stalls mid-stream and before the last byte; tid must not move early
    task automatic t_hist();
        hist_kind = 8'h81;
        u_host.cmd(SCCS_CMD_HIST);
        chk("hist_ready", 8'h01, {7'h0, hist_ready});
        for (int i = 0; i < 128; i++) begin
            if (i == 64 || i == 127) begin
                hist_valid = 1'b0;
                chk_reg(SCCS_OFF_TID, tid);
            end
            hist_valid = 1'b1;
            hist_data = 8'(i) ^ 8'h5A;
            @(negedge clk_sys_in);
        end
        hist_valid = 1'b0;
        tid = tid + 8'h01;
        chk("hist_ready", 8'h00, {7'h0, hist_ready});
        chk_reg(SCCS_OFF_TID, tid);
        chk_reg(SCCS_OFF_CONTENTS, 8'h81);
        chk_reg(SCCS_OFF_WIN_LO, 8'h5A);
        chk_reg(SCCS_OFF_WIN_HI, 8'h7F ^ 8'h5A);
        chk_reg(SCCS_OFF_LAST, SCCS_CMD_HIST);
    endtask

    task automatic t_stop();
        u_host.cmd(SCCS_CMD_MEASURE);
        chk("meas_start", 8'h01, {7'h0, meas_start});
        meas_busy = 1'b1;
        @(negedge clk_sys_in);
        chk("meas_start", 8'h00, {7'h0, meas_start});
        chk("meas_cont", 8'h01, {7'h0, meas_cont});
        chk_reg(SCCS_OFF_LAST, SCCS_CMD_MEASURE);
        u_host.cmd(SCCS_CMD_STOP);
        chk("abort", 8'h01, {7'h0, abort});
        chk("meas_cont", 8'h00, {7'h0, meas_cont});
        meas_busy = 1'b0;
        @(negedge clk_sys_in);
        chk("abort", 8'h00, {7'h0, abort});
        chk("meas_start", 8'h00, {7'h0, meas_start});
        chk_reg(SCCS_OFF_LAST, SCCS_CMD_STOP);
        // a partial histogram is dropped without a tid change
        u_host.cmd(SCCS_CMD_HIST);
        hist_valid = 1'b1;
        repeat (10) @(negedge clk_sys_in);
        hist_valid = 1'b0;
        u_host.cmd(SCCS_CMD_STOP);
        chk("hist_ready", 8'h00, {7'h0, hist_ready});
        chk_reg(SCCS_OFF_TID, tid);
        chk_reg(SCCS_OFF_STATE, SCCS_OPST_IDLE);
    endtask

    task automatic t_unknown();
        u_host.cmd(8'h33);
        chk_reg(SCCS_OFF_STATE, SCCS_OPST_ERROR);
        chk_reg(SCCS_OFF_STATUS, SCCS_STAT_BAD_CMD);
        chk_reg(SCCS_OFF_LAST, SCCS_CMD_STOP);
        u_host.cmd(SCCS_CMD_CALIB);
        meas_busy = 1'b1;
        chk_reg(SCCS_OFF_LAST, SCCS_CMD_CALIB);
        chk_reg(SCCS_OFF_STATE, SCCS_OPST_BUSY);
        meas_busy = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        chk_reg(SCCS_OFF_STATE, SCCS_OPST_IDLE);
    endtask

    // main sequence after four reset cycles
    initial begin
        repeat (4) @(negedge clk_sys_in);
        srst_in = 1'b0;
        t_reset();
        t_serial();
        t_addr();
        t_hist();
        t_stop();
        t_unknown();
        report_and_stop();
    end

    // the whole run needs well under 2000 cycles, so a hang is caught early
    initial begin
        #16000; // 2000 cycles of 8 ns
        bad_count++;
        report_and_stop();
    end
endmodule
